// >>> design/tfc_config_cmd.sv
// Purpose: Toggle configuration command handler and feature word.
// Assumes: rxFrameEnd comes at least one cycle after the last command bit.
// Notes: Nonvolatile bits are mirrored here and written back by handshake.
`timescale 1ns/10ps
`include "tfc_consts.svh"
module tfc_config_cmd #(
    parameter int REPLY_LIMIT_CYC = `TFC_REPLY_LIMIT_MS * `TFC_CLK_KHZ
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic rxBit,
    input wire logic rxBitValid,
    input wire logic rxFrameSync,
    input wire logic rxFrameEnd,
    input wire tfc_pkg::tfc_tag_state_type tagState,
    input wire logic reqRnSeen,
    input wire logic [15:0] handle,
    input wire logic [15:0] rn16,
    input wire logic accessPwdZero,
    input wire logic queryTrExt,
    output logic stateToArb,
    output logic replyValid,
    input wire logic replyReady,
    output logic replyBit,
    output logic replyLast,
    output logic replyExtPreamble,
    input wire logic nvLoadValid,
    input wire logic [8:0] nvLoadWord,
    output logic nvWrReq,
    output logic [8:0] nvWrData,
    input wire logic nvWrDone,
    input wire logic nvWrFail,
    input wire logic epcLocked,
    input wire logic wrReq,
    input wire logic [15:0] wrData,
    output logic wrAck,
    input wire logic rdReq,
    input wire logic [1:0] rdBank,
    input wire logic rdAtCfg,
    input wire logic [15:0] rdRaw,
    output logic rdValid,
    output logic [15:0] rdData,
    input wire logic tamperShortPin,
    input wire logic extSupplyPin,
    input wire logic demodRaw,
    input wire logic demodData,
    output logic [15:0] cfgWord,
    output logic outPin,
    output logic rangeReduce,
    output logic maxBackscatter,
    output logic productStatusAlarm,
    output logic userAreaReadGuard,
    output logic codeBankReadGuard,
    output logic identBankReadGuard
);
    import tfc_pkg::*;
    localparam int WAIT_W = $clog2(REPLY_LIMIT_CYC + 1);
    if (REPLY_LIMIT_CYC < 1) begin : g_chk
        $error("REPLY_LIMIT_CYC must be at least one cycle");
    end

    tfc_fsm_type fsm_ff;
    logic [2:0] temp_ff;
    logic [8:0] perm_ff;
    logic [8:0] pendPerm_ff;
    logic [2:0] tamperSync_ff;
    logic [2:0] extSync_ff;
    logic tamper_ff;
    logic ext_ff;
    logic [71:0] rxShift_ff;
    logic [6:0] rxCnt_ff;
    logic syncSeen_ff;
    logic [48:0] txShift_ff;
    logic [5:0] txCnt_ff;
    logic [5:0] txLen_ff;
    logic txErr_ff;
    logic [WAIT_W-1:0] wait_ff;
    logic stateToArb_ff;
    logic nvWrReq_ff;
    logic [8:0] nvWrData_ff;
    logic extPre_ff;
    logic rdValid_ff;
    logic [15:0] rdData_ff;
    logic [15:0] rxCrc;
    logic [15:0] txCrc;
    logic rxTake;
    logic eval;
    logic cmdHit;
    logic crcOk;
    logic validCmd;
    logic inAccess;
    logic [15:0] mask;
    logic [15:0] effMask;
    logic [15:0] newWord;
    logic txTake;
    logic [5:0] dataLen;
    logic condHit;

    // Bit 0 is the word MSB; reserved bits are tied low here.
    assign cfgWord = {tamper_ff, ext_ff, 2'b00, temp_ff, perm_ff};

    // Pin inputs: a level counts once the second and third stages agree.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            tamperSync_ff <= 3'h0;
            extSync_ff <= 3'h0;
            tamper_ff <= 1'b0;
            ext_ff <= 1'b0;
        end else begin
            tamperSync_ff <= {tamperSync_ff[1:0], tamperShortPin};
            extSync_ff <= {extSync_ff[1:0], extSupplyPin};
            if (tamperSync_ff[1] == tamperSync_ff[2]) begin
                tamper_ff <= tamperSync_ff[2];
            end
            if (extSync_ff[1] == extSync_ff[2]) begin
                ext_ff <= extSync_ff[2];
            end
        end
    end

    // Receive path: counting starts only after a frame-sync.
    assign rxTake = syncSeen_ff & rxBitValid & (rxCnt_ff != `TFC_CMD_BITS);
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rxShift_ff <= 72'h0;
            rxCnt_ff <= 7'h0;
            syncSeen_ff <= 1'b0;
        end else if (rxFrameSync) begin
            rxCnt_ff <= 7'h0;
            syncSeen_ff <= 1'b1;
        end else if (rxFrameEnd) begin
            syncSeen_ff <= 1'b0;
        end else if (rxTake) begin
            rxShift_ff <= {rxShift_ff[70:0], rxBit};
            rxCnt_ff <= rxCnt_ff + 7'd1;
        end
    end

    // The received CRC is run through too, so a clean frame leaves the residue.
    tfc_crc16 u_rxcrc (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clear(rxFrameSync),
        .bitEn(rxTake),
        .bitIn(rxBit),
        .crc(rxCrc)
    );

    assign eval = rxFrameEnd & syncSeen_ff & (fsm_ff == TFC_IDLE);
    assign cmdHit = eval & (rxCnt_ff == `TFC_CMD_BITS)
        & (rxShift_ff[71:56] == `TFC_OPCODE) & (rxShift_ff[55:48] == 8'h00);
    assign crcOk = (rxCrc == `TFC_CRC_RESIDUE);
    assign mask = rxShift_ff[47:32] ^ rn16;
    assign inAccess = (tagState == TFC_OPEN) | (tagState == TFC_SECURED);
    assign validCmd = cmdHit & inAccess & crcOk & reqRnSeen & !nvWrReq_ff
        & (rxShift_ff[31:16] == handle)
        & ((mask & `TFC_MASK_RSVD) == 16'h0000);
    // Indicator and reserved positions are dropped from the mask.
    assign effMask = ((tagState == TFC_OPEN) | accessPwdZero) ? 16'h0000
        : (mask & `TFC_MASK_TOGGLE);
    assign newWord = cfgWord ^ effMask;

    assign wrAck = wrReq & !epcLocked & (fsm_ff == TFC_IDLE)
        & !nvWrReq_ff & !rxFrameEnd;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stateToArb_ff <= 1'b0;
        end else begin
            stateToArb_ff <= cmdHit & ((tagState == TFC_ARBITRATE)
                | (tagState == TFC_REPLY) | (tagState == TFC_ACK));
        end
    end

    // Temporary bits are volatile and come up cleared.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            temp_ff <= `TFC_TEMP_RESET;
        end else if (validCmd) begin
            temp_ff <= newWord[`TFC_TEMP_HI:`TFC_TEMP_LO];
        end else if (wrAck) begin
            temp_ff <= wrData[`TFC_TEMP_HI:`TFC_TEMP_LO];
        end
    end

    // Permanent mirror: loaded from nonvolatile memory after release.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            perm_ff <= `TFC_PERM_RESET;
        end else if (nvLoadValid) begin
            perm_ff <= nvLoadWord;
        end else if (fsm_ff == TFC_WAITNV && nvWrDone) begin
            perm_ff <= pendPerm_ff;
        end else if (validCmd && (effMask & `TFC_MASK_PERM) == 16'h0000) begin
            perm_ff <= newWord[`TFC_PERM_HI:0];
        end else if (wrAck) begin
            perm_ff <= wrData[`TFC_PERM_HI:0];
        end
    end

    // Write-back request is held until the memory answers, or until an error reply reaches its CRC load.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            nvWrReq_ff <= 1'b0;
            nvWrData_ff <= 9'h000;
            pendPerm_ff <= 9'h000;
        end else if (nvWrReq_ff) begin
            if (nvWrDone || nvWrFail || fsm_ff == TFC_CRCLD) begin
                nvWrReq_ff <= 1'b0;
            end
        end else if (validCmd && (effMask & `TFC_MASK_PERM) != 16'h0000) begin
            nvWrReq_ff <= 1'b1;
            nvWrData_ff <= newWord[`TFC_PERM_HI:0];
            pendPerm_ff <= newWord[`TFC_PERM_HI:0];
        end else if (wrAck) begin
            nvWrReq_ff <= 1'b1;
            nvWrData_ff <= wrData[`TFC_PERM_HI:0];
        end
    end

    // Transmit path.
    assign dataLen = txLen_ff - `TFC_CRC_LEN;
    assign txTake = (fsm_ff == TFC_SEND) & replyReady;
    tfc_crc16 u_txcrc (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clear(fsm_ff == TFC_IDLE),
        .bitEn(txTake & (txCnt_ff < dataLen)),
        .bitIn(txShift_ff[48]),
        .crc(txCrc)
    );

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fsm_ff <= TFC_IDLE;
            txShift_ff <= 49'h0;
            txCnt_ff <= 6'h0;
            txLen_ff <= `TFC_OK_LEN;
            txErr_ff <= 1'b0;
            wait_ff <= '0;
        end else begin
            case (fsm_ff)
                TFC_IDLE: begin
                    txCnt_ff <= 6'h0;
                    wait_ff <= '0;
                    if (validCmd && tagState == TFC_SECURED
                        && (effMask & `TFC_MASK_PERM) != 16'h0000) begin
                        fsm_ff <= TFC_WAITNV;
                        txShift_ff <= {1'b0, newWord, handle, 16'h0000};
                    end else if (validCmd) begin
                        fsm_ff <= TFC_SEND;
                        txShift_ff <= {1'b0, newWord, handle, 16'h0000};
                        txLen_ff <= `TFC_OK_LEN;
                        txErr_ff <= 1'b0;
                    end
                end
                TFC_WAITNV: begin
                    wait_ff <= wait_ff + 1'b1;
                    if (nvWrDone) begin
                        fsm_ff <= TFC_SEND;
                        txLen_ff <= `TFC_OK_LEN;
                        txErr_ff <= 1'b0;
                    end else if (nvWrFail
                        || wait_ff == WAIT_W'(REPLY_LIMIT_CYC - 1)) begin
                        // Past the reader's wait a late reply is useless.
                        fsm_ff <= TFC_SEND;
                        txShift_ff <= {1'b1, `TFC_ERR_CODE, handle, 24'h0};
                        txLen_ff <= `TFC_ERR_LEN;
                        txErr_ff <= 1'b1;
                    end
                end
                TFC_CRCLD: begin
                    txShift_ff[48:33] <= ~txCrc;
                    fsm_ff <= TFC_SEND;
                end
                default: begin
                    if (txTake) begin
                        txShift_ff <= {txShift_ff[47:0], 1'b0};
                        txCnt_ff <= txCnt_ff + 6'd1;
                        if (txCnt_ff == txLen_ff - 6'd1) begin
                            fsm_ff <= TFC_IDLE;
                        end else if (txCnt_ff == dataLen - 6'd1) begin
                            fsm_ff <= TFC_CRCLD;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            extPre_ff <= 1'b0;
        end else if (fsm_ff == TFC_IDLE || fsm_ff == TFC_WAITNV) begin
            extPre_ff <= nvWrDone | validCmd | queryTrExt;
            if (fsm_ff == TFC_WAITNV && !nvWrDone) begin
                extPre_ff <= queryTrExt;
            end
        end
    end

    // Reads: the word itself, or bank data veiled by its guard.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdValid_ff <= 1'b0;
            rdData_ff <= 16'h0000;
        end else begin
            rdValid_ff <= rdReq;
            if (rdReq) begin
                if (rdAtCfg) begin
                    rdData_ff <= cfgWord;
                end else if (rdBank == `TFC_BANK_USER && userAreaReadGuard) begin
                    rdData_ff <= 16'h0000;
                end else if (rdBank == `TFC_BANK_CODE && codeBankReadGuard) begin
                    rdData_ff <= 16'h0000;
                end else if (rdBank == `TFC_BANK_IDENT && identBankReadGuard) begin
                    rdData_ff <= 16'h0000;
                end else begin
                    rdData_ff <= rdRaw;
                end
            end
        end
    end

    // Trigger one selects the shorted pad, zero the open pad.
    assign condHit = perm_ff[`TFC_P_TRIG] ? tamper_ff : !tamper_ff;
    assign rangeReduce = perm_ff[`TFC_P_RR]
        & (!perm_ff[`TFC_P_COND] | condHit);
    assign outPin = !temp_ff[`TFC_T_PASS]
        ? (perm_ff[`TFC_P_DOUT] ^ temp_ff[`TFC_T_INV])
        : (temp_ff[`TFC_T_RAW] ? demodRaw : demodData);
    assign maxBackscatter = perm_ff[`TFC_P_STRENGTH];
    assign productStatusAlarm = perm_ff[`TFC_P_PSF];
    assign userAreaReadGuard = perm_ff[`TFC_P_UGUARD];
    assign codeBankReadGuard = perm_ff[`TFC_P_CGUARD];
    assign identBankReadGuard = perm_ff[`TFC_P_IGUARD];

    assign stateToArb = stateToArb_ff;
    assign replyValid = (fsm_ff == TFC_SEND);
    assign replyBit = txShift_ff[48];
    assign replyLast = (fsm_ff == TFC_SEND) & (txCnt_ff == txLen_ff - 6'd1);
    assign replyExtPreamble = extPre_ff;
    assign nvWrReq = nvWrReq_ff;
    assign nvWrData = nvWrData_ff;
    assign rdValid = rdValid_ff;
    assign rdData = rdData_ff;

    arb_move_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        cmdHit && tagState == TFC_ACK |=> stateToArb && fsm_ff == TFC_IDLE)
        else $error("acknowledged state did not fall back to arbitrate");
    ready_quiet_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        eval && (tagState == TFC_READY || tagState == TFC_KILLED)
        |=> fsm_ff == TFC_IDLE && !stateToArb)
        else $error("ready or killed state reacted to command");
    open_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        validCmd && tagState == TFC_OPEN && !nvLoadValid
        |=> $stable(perm_ff) && $stable(temp_ff) && replyValid)
        else $error("open state changed the word or gave no reply");
    bad_crc_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        cmdHit && !crcOk |=> fsm_ff == TFC_IDLE ##1 fsm_ff == TFC_IDLE)
        else $error("command with bad CRC was answered");
    rsvd_mask_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        cmdHit && (mask & `TFC_MASK_RSVD) != 16'h0000 |=> !replyValid)
        else $error("reserved mask bit did not void the command");
    ext_pre_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        replyValid && !txErr_ff |-> replyExtPreamble)
        else $error("successful reply without extended preamble");
    nv_wait_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        fsm_ff == TFC_WAITNV && !nvWrDone
        |=> !replyValid || txErr_ff)
        else $error("reply started before the change completed");
    hdr_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        replyValid && txCnt_ff == 6'h0 && !txErr_ff |-> !replyBit)
        else $error("reply header is not zero");
    wr_lock_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        wrReq && epcLocked && !validCmd |-> !wrAck ##1 $stable(temp_ff))
        else $error("locked bank accepted a plain write");
    rd_guard_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        rdReq && !rdAtCfg && rdBank == `TFC_BANK_IDENT && identBankReadGuard
        |=> rdValid && rdData == 16'h0000)
        else $error("guarded bank read returned data");
    rsvd_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        wrAck |=> cfgWord[13:12] == 2'b00)
        else $error("reserved bits read as one");
endmodule

// >>> design/tfc_consts.svh
// Purpose: Shared constants of the feature configuration command block.
// Assumes: Bit 0 of the configuration word is the MSB of the 16-bit word.
// Notes: Word positions below are the word index, that is 15 minus bit.
// Functional notes
// - Command: opcode E007h, eight zero bits, data, handle, CRC-16.
// - Data field is toggle mask XOR RN16; a one selects a bit.
// - Reply: zero header, configuration word, handle, CRC over those.
// - No reply in ready/killed; arbitrate/reply/acknowledged go to arbitrate.
// - Open state or zero access password: toggles read as zero.
// - Bad CRC or wrong handle: command ignored, state kept; in arbitrate/reply/acknowledged stateToArb still pulses.
// - Command CRC spans first opcode bit to last handle bit.
// - Frame-sync and a prior Req_RN are needed, else ignored.
// - Any reserved mask bit set makes the command ignored.
// - A one in the mask inverts that bit; repeating restores it.
// - Indicator bits follow only the tamper and supply inputs.
// - A successful reply always uses the extended preamble.
// - Secured with a change: reply after the change completes.
// - Internal failure: backscatter a standard error code instead.
// - Word sits at 200h in the code bank: read, select, write.
// - Bits 0-7: tamper, supply, two reserved, invert, pass, mode, cond.
// - Bits 8-15: trigger, strength, output, reduction, three guards, alarm.
// - Invert, passthrough and data/raw bits clear at power-up.
// - Bits 7 to 15 are held in nonvolatile memory.
// - Plain WRITE changes bits only while the code bank is unlocked.
// - Conditional reduction needs bits 7 and 11; bit 8 picks short.
// - A set read guard makes reads of that bank return zeros; rdAtCfg reads still return the word.
`ifndef TFC_CONSTS_SVH
`define TFC_CONSTS_SVH
`define TFC_OPCODE 16'hE007
`define TFC_CMD_BITS 7'd72
`define TFC_CRC_POLY 16'h1021
`define TFC_CRC_PRESET 16'hFFFF
`define TFC_CRC_RESIDUE 16'h1D0F
`define TFC_CFG_ADDR 12'h200
`define TFC_POS_TAMPER 15
`define TFC_POS_EXTSUP 14
`define TFC_TEMP_HI 11
`define TFC_TEMP_LO 9
`define TFC_PERM_HI 8
`define TFC_MASK_RSVD 16'h3000
`define TFC_MASK_TOGGLE 16'h0FFF
`define TFC_MASK_PERM 16'h01FF
`define TFC_P_COND 8
`define TFC_P_TRIG 7
`define TFC_P_STRENGTH 6
`define TFC_P_DOUT 5
`define TFC_P_RR 4
`define TFC_P_UGUARD 3
`define TFC_P_CGUARD 2
`define TFC_P_IGUARD 1
`define TFC_P_PSF 0
`define TFC_T_INV 2
`define TFC_T_PASS 1
`define TFC_T_RAW 0
`define TFC_TEMP_RESET 3'h0
`define TFC_PERM_RESET 9'h000
`define TFC_OK_LEN 6'd49
`define TFC_ERR_LEN 6'd41
`define TFC_CRC_LEN 6'd16
`define TFC_ERR_CODE 8'h0F
`define TFC_BANK_CODE 2'h1
`define TFC_BANK_IDENT 2'h2
`define TFC_BANK_USER 2'h3
`define TFC_REPLY_LIMIT_MS 20
`define TFC_CLK_KHZ 20000
`endif

// >>> design/tfc_crc16.sv
// Purpose: Bit-serial CRC-16 register.
// Assumes: MSB-first bits, one per enable.
// Notes: Clear wins over a bit in the same cycle.
`timescale 1ns/10ps
`include "tfc_consts.svh"
module tfc_crc16 (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clear,
    input wire logic bitEn,
    input wire logic bitIn,
    output logic [15:0] crc
);
    logic [15:0] crc_ff;
    logic fb;
    assign fb = bitIn ^ crc_ff[15];
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            crc_ff <= `TFC_CRC_PRESET;
        end else if (clear) begin
            crc_ff <= `TFC_CRC_PRESET;
        end else if (bitEn) begin
            crc_ff <= {crc_ff[14:0], 1'b0} ^ (fb ? `TFC_CRC_POLY : 16'h0000);
        end
    end
    assign crc = crc_ff;
endmodule

// >>> design/tfc_pkg.sv
// Purpose: Types of the feature configuration command block.
// Assumes: Tag state codes are agreed with the protocol state machine.
// Notes: Holds types only; numbers live in the constants header.
package tfc_pkg;
    typedef enum logic [2:0] {
        TFC_READY = 3'h0,
        TFC_ARBITRATE = 3'h1,
        TFC_REPLY = 3'h2,
        TFC_ACK = 3'h3,
        TFC_OPEN = 3'h4,
        TFC_SECURED = 3'h5,
        TFC_KILLED = 3'h6
    } tfc_tag_state_type;
    typedef enum logic [1:0] {
        TFC_IDLE = 2'h0,
        TFC_WAITNV = 2'h1,
        TFC_CRCLD = 2'h2,
        TFC_SEND = 2'h3
    } tfc_fsm_type;
endpackage

// >>> dv/tfc_config_cmd_test.sv
// Purpose: Self-checking bench of the feature configuration handler.
// Assumes: Nonvolatile writes are answered one cycle after the request.
// Notes: The error case comes from a failed write, so the short reply limit is never reached.
`timescale 1ns/10ps
module tfc_config_cmd_test;
    import tfc_pkg::*;
    logic ref_clk = 1'b0, nrst = 1'b0, failNv = 1'b0;
    logic rxBit, rxBitValid, rxFrameSync, rxFrameEnd, replyReady;
    logic replyValid, replyBit, replyLast, replyExtPreamble, stateToArb;
    logic reqRnSeen = 1'b1, accessPwdZero = 1'b0, queryTrExt = 1'b0;
    logic nvLoadValid = 1'b0, nvWrDone = 1'b0, nvWrFail = 1'b0;
    logic epcLocked = 1'b1, wrReq = 1'b0, rdReq = 1'b0, rdAtCfg = 1'b0;
    logic nvWrReq, wrAck, rdValid, tamperPin = 1'b0;
    logic outPin, rangeReduce, maxBackscatter, productStatusAlarm;
    logic [15:0] handle = 16'hA5C3, rn16 = 16'h3C5A, wrData = 16'h0000;
    logic [15:0] rdRaw = 16'hBEEF, cfgWord, rdData;
    logic [8:0] nvLoadWord = 9'h040, nvWrData;
    logic [1:0] rdBank = 2'h1;
    logic [48:0] rep;
    tfc_tag_state_type tagState = TFC_SECURED;
    int failures = 0, n_checks = 0, cyc = 0, arbs = 0;
    always #25 ref_clk = ~ref_clk;
    tfc_config_cmd #(.REPLY_LIMIT_CYC(50)) tfc_config_cmd_i (.ref_clk, .nrst,
        .rxBit, .rxBitValid, .rxFrameSync, .rxFrameEnd, .tagState, .reqRnSeen,
        .handle, .rn16, .accessPwdZero, .queryTrExt, .stateToArb, .replyValid,
        .replyReady, .replyBit, .replyLast, .replyExtPreamble, .nvLoadValid,
        .nvLoadWord, .nvWrReq, .nvWrData, .nvWrDone, .nvWrFail, .epcLocked,
        .wrReq, .wrData, .wrAck, .rdReq, .rdBank, .rdAtCfg, .rdRaw, .rdValid,
        .rdData, .tamperShortPin(tamperPin), .extSupplyPin(1'b0),
        .demodRaw(1'b0), .demodData(1'b0), .cfgWord, .outPin, .rangeReduce,
        .maxBackscatter, .productStatusAlarm, .userAreaReadGuard(),
        .codeBankReadGuard(), .identBankReadGuard());
    tfc_reader_model tfc_reader_model_i (.ref_clk, .replyValid, .replyBit,
        .replyLast, .replyExtPreamble, .rxBit, .rxBitValid, .rxFrameSync,
        .rxFrameEnd, .replyReady);
    always @(posedge ref_clk) begin
        nvWrDone <= nvWrReq && !nvWrDone && !nvWrFail && !failNv;
        nvWrFail <= nvWrReq && !nvWrDone && !nvWrFail && failNv;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (stateToArb === 1'b1) arbs <= arbs + 1;
        if (cyc == 20000) begin
            failures++;
            close_out();
        end
    end
    function automatic logic [15:0] crc16(input logic [71:0] d, input int n);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int i = 0; i < n; i++) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[71-i]) ? 16'h1021 : 16'h0000);
        end
        return c;
    endfunction
    task automatic chk(input logic [48:0] got, input logic [48:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input tfc_tag_state_type st, input logic [15:0] m,
                       input logic bad, output int n);
        logic [55:0] b;
        logic [71:0] c;
        b = {16'hE007, 8'h00, m ^ rn16, handle};
        c = {b, ~crc16({b, 16'h0000}, 56)};
        c[0] = c[0] ^ bad;
        tagState <= st;
        @(posedge ref_clk);
        tfc_reader_model_i.send(c);
        tfc_reader_model_i.take(rep, n);
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic expect_ok(input logic [15:0] w, input int n);
        logic [32:0] h;
        h = {1'b0, w, handle};
        chk(49'(n), 49'd49);
        chk(rep, {h, ~crc16({h, 39'h0}, 33)});
        chk(49'(tfc_reader_model_i.extSeen), 49'd1);
        chk(49'(cfgWord), 49'(w));
    endtask
    task automatic quiet(input int n, input logic [15:0] w);
        chk(49'(n), 49'd0);
        chk(49'(cfgWord), 49'(w));
    endtask
    task automatic rd(input logic [1:0] b, input logic at, input logic [15:0] e);
        rdBank <= b;
        rdAtCfg <= at;
        rdReq <= 1'b1;
        @(posedge ref_clk);
        rdReq <= 1'b0;
        @(posedge ref_clk);
        chk(49'(rdValid), 49'd1);
        chk(49'(rdData), 49'(e));
    endtask
    // Request stays up until taken, or gives up after twenty cycles.
    task automatic wr(input logic [15:0] d);
        wrData <= d;
        wrReq <= 1'b1;
        for (int k = 0; k < 20; k++) begin
            @(posedge ref_clk);
            if (wrAck === 1'b1) break;
        end
        wrReq <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic close_out();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        int n;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        nvLoadValid <= 1'b1;
        @(posedge ref_clk);
        nvLoadValid <= 1'b0;
        @(posedge ref_clk);
        chk(49'(cfgWord), 49'h0040);
        run(TFC_OPEN, 16'h0011, 1'b0, n);
        expect_ok(16'h0040, n);
        run(TFC_SECURED, 16'h0002, 1'b0, n);
        expect_ok(16'h0042, n);
        rd(2'h2, 1'b0, 16'h0000);
        rd(2'h3, 1'b0, 16'hBEEF);
        rd(2'h1, 1'b1, 16'h0042);
        run(TFC_SECURED, 16'h0002, 1'b0, n);
        expect_ok(16'h0040, n);
        run(TFC_SECURED, 16'hC800, 1'b0, n);
        expect_ok(16'h0840, n);
        chk(49'(outPin), 49'd1);
        chk(49'(maxBackscatter), 49'd1);
        accessPwdZero <= 1'b1;
        run(TFC_SECURED, 16'h0001, 1'b0, n);
        expect_ok(16'h0840, n);
        accessPwdZero <= 1'b0;
        run(TFC_SECURED, 16'h1000, 1'b0, n);
        quiet(n, 16'h0840);
        run(TFC_SECURED, 16'h0001, 1'b1, n);
        quiet(n, 16'h0840);
        reqRnSeen <= 1'b0;
        run(TFC_SECURED, 16'h0001, 1'b0, n);
        quiet(n, 16'h0840);
        reqRnSeen <= 1'b1;
        run(TFC_SECURED, 16'h0000, 1'b0, n);
        expect_ok(16'h0840, n);
        for (int s = 0; s < 7; s++) begin
            if (s != 4 && s != 5) begin
                run(tfc_tag_state_type'(s), 16'h0001, 1'b0, n);
                quiet(n, 16'h0840);
            end
        end
        chk(49'(arbs), 49'd3);
        failNv <= 1'b1;
        run(TFC_SECURED, 16'h0001, 1'b0, n);
        failNv <= 1'b0;
        chk(49'(n), 49'd41);
        chk(49'(rep[40:16]), 49'({1'b1, 8'h0F, handle}));
        chk(49'(cfgWord), 49'h0840);
        wr(16'h3001);
        chk(49'(cfgWord), 49'h0840);
        epcLocked <= 1'b0;
        wr(16'h3001);
        chk(49'(cfgWord), 49'h0001);
        chk(49'(outPin), 49'd0);
        chk(49'(productStatusAlarm), 49'd1);
        tamperPin <= 1'b1;
        wr(16'h019F);
        epcLocked <= 1'b1;
        chk(49'(cfgWord), 49'h819F);
        chk(49'(rangeReduce), 49'd1);
        rd(2'h3, 1'b0, 16'h0000);
        rd(2'h1, 1'b0, 16'h0000);
        tamperPin <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk(49'(rangeReduce), 49'd0);
        close_out();
    end
endmodule

// >>> dv/tfc_reader_model.sv
// Purpose: Behavioural reader that frames commands and takes replies.
// Assumes: The bench calls its tasks just after a rising clock edge.
// Notes: Between bits the line shows the inverse of the last bit sent.
`timescale 1ns/10ps
module tfc_reader_model (
    input wire logic ref_clk,
    input wire logic replyValid,
    input wire logic replyBit,
    input wire logic replyLast,
    input wire logic replyExtPreamble,
    output logic rxBit,
    output logic rxBitValid,
    output logic rxFrameSync,
    output logic rxFrameEnd,
    output logic replyReady
);
    logic extSeen = 1'b0;
    initial begin
        rxBit = 1'b0;
        rxBitValid = 1'b0;
        rxFrameSync = 1'b0;
        rxFrameEnd = 1'b0;
        replyReady = 1'b1;
    end
    task automatic send(input logic [71:0] c);
        rxFrameSync <= 1'b1;
        @(posedge ref_clk);
        rxFrameSync <= 1'b0;
        for (int i = 0; i < 72; i++) begin
            rxBit <= c[71-i];
            rxBitValid <= 1'b1;
            @(posedge ref_clk);
            rxBit <= ~c[71-i];
            rxBitValid <= 1'b0;
            @(posedge ref_clk);
        end
        rxFrameEnd <= 1'b1;
        @(posedge ref_clk);
        rxFrameEnd <= 1'b0;
    endtask
    // Ready stalls one cycle in four, as a busy modulator would.
    task automatic take(output logic [48:0] r, output int n);
        r = '0;
        n = 0;
        for (int k = 0; k < 200; k++) begin
            @(posedge ref_clk);
            if (replyValid === 1'b1 && replyReady === 1'b1) begin
                r = {r[47:0], replyBit};
                extSeen = replyExtPreamble;
                n++;
                if (replyLast === 1'b1) break;
            end
            replyReady <= (k % 4 != 2);
        end
        replyReady <= 1'b1;
    endtask
endmodule
